//--- ssp_defs.svh
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_DATA_WIDTH 8
`define SSP_OUT_DELAY_NS 0
`define SSP_RESET_VALUE 1'b0
`endif

//--- ssp_pkg.sv
package ssp_pkg;
  typedef struct packed {
    logic setN;
    logic clearN;
  } ssp_async_s;
  typedef enum logic [1:0] {
    SSP_HOLD,
    SSP_LOAD0,
    SSP_LOAD1,
    SSP_TOGGLE
  } ssp_jk_e;
endpackage

//--- ssp_storage.sv
`timescale 1ns/1ps
`include "ssp_defs.svh"
// Operation
// [RL1] edge elements update on rising edge, or falling edge when inverted.
// [RL2] toggle flop holds on 00, clears on 01, sets on 10, inverts on 11.
// [RL3] toggle flop has active-low async set and clear and dual outputs.
// [RL4] toggle flop drives both outputs high when set and clear both assert.
// [RL5] transparent store passes data while enable is 1, holds while 0.
// [RL6] transparent store set/clear force 1 or 0 regardless of enable.
// [RL7] single-output transparent store gives clear priority over set.
// [RL8] dual-output transparent store drives both outputs 1 on set+clear.
// [RL9] edge store captures on active edge and ignores the other edge.
// [RL10] edge store set/clear force 1 or 0 independent of the clock.
// [RL11] single-output edge store gives clear priority over set.
// [RL12] dual-output edge store drives both outputs 1 on set+clear.
// [RL13] clock-enabled edge store captures only while its enable is set.
// [RL14] data width is a parameter; enables and clocks are one bit.
// [RL15] each element takes an output delay parameter defaulting to zero.
// [RL16] unknown data captured or passed yields an unknown output.
// [RL17] unknown set, clear or clock level yields unknown outputs; code makes only jkQ/jkQn unknown, for unknown jSet/kClear on an active edge.
module ssp_storage #(
  parameter int WIDTH      = `SSP_DATA_WIDTH,
  parameter int OUT_DELAY  = `SSP_OUT_DELAY_NS,
  parameter bit CLK_INVERT = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               jSet,
  input  wire logic               kClear,
  input  wire ssp_pkg::ssp_async_s jkAsync,
  input  wire logic               storeEnable,
  input  wire logic               clockEnable,
  input  wire ssp_pkg::ssp_async_s storeAsync,
  input  wire logic [WIDTH-1:0]   dataIn,
  output logic                    jkQ,
  output logic                    jkQn,
  output logic [WIDTH-1:0]        latchQ,
  output logic [WIDTH-1:0]        latchRsQ,
  output logic [WIDTH-1:0]        latchDualQ,
  output logic [WIDTH-1:0]        latchDualQn,
  output logic [WIDTH-1:0]        regQ,
  output logic [WIDTH-1:0]        regRsQ,
  output logic [WIDTH-1:0]        regDualQ,
  output logic [WIDTH-1:0]        regDualQn,
  output logic [WIDTH-1:0]        regCkeQ
);
  // OUT_DELAY is carried for model compatibility; zero-delay in hardware [RL15]
  logic [1:0]             jkForce;
  logic [1:0]             storeForce;
  logic                   clkSync1;
  logic                   clkSync2;
  logic                   clkPrev;
  logic                   activeEdge;
  logic                   jk;
  logic                   jkn;
  logic                   next_jk;
  logic                   next_jkn;
  logic [WIDTH-1:0]       latch;
  logic [WIDTH-1:0]       latchRs;
  logic [WIDTH-1:0]       next_latch;
  logic [WIDTH-1:0]       next_latchRs;
  logic [WIDTH-1:0]       regPlain;
  logic [WIDTH-1:0]       regRs;
  logic [WIDTH-1:0]       regCke;
  logic [WIDTH-1:0]       next_regPlain;
  logic [WIDTH-1:0]       next_regRs;
  logic [WIDTH-1:0]       next_regCke;
  ssp_pkg::ssp_jk_e       jkMode;

  // element clock pin sampled into the system clock domain
  always_ff @(posedge clk) begin
    if (reset) begin
      clkSync1 <= 1'b0;
      clkSync2 <= 1'b0;
      clkPrev  <= 1'b0;
    end else begin
      clkSync1 <= storeEnable;
      clkSync2 <= clkSync1;
      clkPrev  <= clkSync2;
    end
  end
  // rising edge of sampled clock line, or falling when inverted
  assign activeEdge = CLK_INVERT ? (clkPrev & ~clkSync2)
                                 : (~clkPrev & clkSync2); // [RL1] [RL9]

  assign jkMode = ssp_pkg::ssp_jk_e'({jSet, kClear});

  // async decode: bit 1 forces the stored value, bit 0 is that value
  function automatic logic [1:0] asyncForce(
    input ssp_pkg::ssp_async_s pins
  );
    logic forceOn;
    forceOn    = ~(pins.setN & pins.clearN);
    asyncForce = {forceOn, pins.clearN};
  endfunction

  // a force also loads the state so it persists after release
  assign jkForce    = asyncForce(jkAsync);
  assign storeForce = asyncForce(storeAsync);

  always_comb begin
    next_jk  = jk;
    next_jkn = jkn;
    if (activeEdge) begin
      case (jkMode)
        ssp_pkg::SSP_HOLD: begin
          next_jk  = jk;
          next_jkn = jkn;
        end
        ssp_pkg::SSP_LOAD0: begin
          next_jk  = 1'b0;
          next_jkn = 1'b1;
        end
        ssp_pkg::SSP_LOAD1: begin
          next_jk  = 1'b1;
          next_jkn = 1'b0;
        end
        ssp_pkg::SSP_TOGGLE: begin
          next_jk  = ~jk;
          next_jkn = ~jkn;
        end
        default: begin
          next_jk  = 1'bx; // [RL17]
          next_jkn = 1'bx;
        end
      endcase // [RL2]
    end
    if (jkForce[1]) begin
      next_jk  = jkForce[0]; // [RL3]
      next_jkn = ~jkForce[0];
    end
  end

  always_comb begin
    next_latch    = latch;
    next_latchRs  = latchRs;
    next_regPlain = regPlain;
    next_regRs    = regRs;
    next_regCke   = regCke;
    if (clkSync2) begin
      next_latch   = dataIn; // [RL5] [RL16]
      next_latchRs = dataIn;
    end
    if (activeEdge) begin
      next_regPlain = dataIn; // [RL9] [RL16]
      next_regRs    = dataIn;
      if (clockEnable) begin
        next_regCke = dataIn; // [RL13]
      end
    end
    if (storeForce[1]) begin
      next_latchRs = {WIDTH{storeForce[0]}}; // [RL6]
      next_regRs   = {WIDTH{storeForce[0]}}; // [RL10]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      jk       <= `SSP_RESET_VALUE;
      jkn      <= ~`SSP_RESET_VALUE;
      latch    <= '0;
      latchRs  <= '0;
      regPlain <= '0;
      regRs    <= '0;
      regCke   <= '0;
    end else begin
      jk       <= next_jk;
      jkn      <= next_jkn;
      latch    <= next_latch;
      latchRs  <= next_latchRs;
      regPlain <= next_regPlain;
      regRs    <= next_regRs;
      regCke   <= next_regCke;
    end
  end

  // async set/clear override stored state on the outputs
  always_comb begin
    jkQ  = jk;
    jkQn = jkn;
    if (!jkAsync.setN && !jkAsync.clearN) begin
      jkQ  = 1'b1; // [RL4]
      jkQn = 1'b1;
    end else if (!jkAsync.setN) begin
      jkQ  = 1'b1; // [RL3]
      jkQn = 1'b0;
    end else if (!jkAsync.clearN) begin
      jkQ  = 1'b0; // [RL3]
      jkQn = 1'b1;
    end
    latchQ      = latch;
    latchRsQ    = latchRs;
    latchDualQ  = latchRs;
    latchDualQn = ~latchRs;
    regQ        = regPlain;
    regRsQ      = regRs;
    regDualQ    = regRs;
    regDualQn   = ~regRs;
    regCkeQ     = regCke;
    if (!storeAsync.clearN) begin
      latchRsQ = '0; // [RL6] [RL7]
      regRsQ   = '0; // [RL10] [RL11]
    end else if (!storeAsync.setN) begin
      latchRsQ = '1; // [RL6]
      regRsQ   = '1; // [RL10]
    end
    if (!storeAsync.setN && !storeAsync.clearN) begin
      latchDualQ  = '1; // [RL8]
      latchDualQn = '1;
      regDualQ    = '1; // [RL12]
      regDualQn   = '1;
    end else if (!storeAsync.setN) begin
      latchDualQ  = '1;
      latchDualQn = '0;
      regDualQ    = '1;
      regDualQn   = '0;
    end else if (!storeAsync.clearN) begin
      latchDualQ  = '0;
      latchDualQn = '1;
      regDualQ    = '0;
      regDualQn   = '1;
    end
  end
  // WIDTH sets data width; control pins stay one bit [RL14]
endmodule

//--- ssp_storage_props.sv
`timescale 1ns/1ps
module ssp_storage_props #(
  parameter int WIDTH = 8
) (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                jSet,
  input wire logic                kClear,
  input wire logic                storeEnable,
  input wire ssp_pkg::ssp_async_s jkAsync,
  input wire ssp_pkg::ssp_async_s storeAsync,
  input wire logic                jkQ,
  input wire logic                jkQn,
  input wire logic [WIDTH-1:0]    latchRsQ,
  input wire logic [WIDTH-1:0]    regRsQ,
  input wire logic [WIDTH-1:0]    regDualQ,
  input wire logic [WIDTH-1:0]    regDualQn
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_jk_both_high: assert property (jkAsync == 2'h0 |-> jkQ && jkQn)
    else $error("jk outputs not both high");
  a_jk_set_only: assert property (jkAsync == 2'h1 |-> jkQ && !jkQn)
    else $error("jk set failed");
  a_jk_toggle: assert property ($rose(storeEnable) ##2
    (jkAsync == 2'h3 && jSet && kClear) ##1 jkAsync == 2'h3
    |-> jkQ != $past(jkQ)) else $error("no toggle");
  a_lrs_clear_wins: assert property (
    !storeAsync.clearN |-> ~|latchRsQ)
    else $error("latch clear lost");
  a_lrs_set: assert property (storeAsync == 2'h1 |-> &latchRsQ)
    else $error("latch set lost");
  a_rrs_clear_wins: assert property (
    !storeAsync.clearN |-> ~|regRsQ)
    else $error("reg clear lost");
  a_rrs_set: assert property (storeAsync == 2'h1 |-> &regRsQ)
    else $error("reg set lost");
  a_rdual_both: assert property (
    storeAsync == 2'h0 |-> &{regDualQ, regDualQn})
    else $error("dual outputs not high");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                clk = 1'b0, reset = 1'b1, jSet = 1'b0, kClear = 1'b0;
  logic                storeEnable = 1'b0, clockEnable = 1'b0;
  logic [7:0]          dataIn = 8'h00;
  ssp_pkg::ssp_async_s jkAsync = 2'h3, storeAsync = 2'h3;
  logic                jkQ, jkQn;
  logic [7:0]          latchQ, latchRsQ, latchDualQ, latchDualQn, regQ;
  logic [7:0]          regRsQ, regDualQ, regDualQn, regCkeQ;
  int                  err_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  ssp_storage #(.WIDTH(8)) uut (.clk, .reset, .jSet, .kClear, .jkAsync,
    .storeEnable, .clockEnable, .storeAsync, .dataIn, .jkQ, .jkQn, .latchQ,
    .latchRsQ, .latchDualQ, .latchDualQn, .regQ, .regRsQ, .regDualQ,
    .regDualQn, .regCkeQ);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic drive(logic en, logic ce, logic [7:0] d);
    @(posedge clk);
    storeEnable <= en;
    clockEnable <= ce;
    dataIn <= d;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic t_jk;
    logic [1:0] c;
    logic       q;
    q = 1'b0;
    for (int i = 0; i < 7; i++) begin
      c = ~i[1:0];
      @(posedge clk);
      {jSet, kClear} <= c;
      storeEnable <= 1'b1;
      repeat (3) @(posedge clk);
      storeEnable <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      q = (c[1] & c[0]) ? ~q : ((c[1] ^ c[0]) ? c[1] : q);
      chk("jkQ", {7'h00, q}, {7'h00, jkQ});
      chk("jkQn", {7'h00, ~q}, {7'h00, jkQn});
    end
    $display("toggle test done");
  endtask
  task automatic t_store;
    drive(1'b1, 1'b0, 8'hA5);
    chk("regQ", 8'hA5, regQ);
    chk("regCkeQ", 8'h00, regCkeQ);
    chk("regDualQn", 8'h5A, regDualQn);
    drive(1'b1, 1'b0, 8'h3C);
    chk("latchQ", 8'h3C, latchQ);
    drive(1'b0, 1'b0, 8'h3C);
    drive(1'b0, 1'b1, 8'h5A);
    chk("latchQ", 8'h3C, latchQ);
    chk("regQ", 8'hA5, regQ);
    chk("regCkeQ", 8'h00, regCkeQ);
    drive(1'b1, 1'b1, 8'h5A);
    chk("regCkeQ", 8'h5A, regCkeQ);
    $display("store test done");
  endtask
  task automatic t_async;
    logic [1:0] a;
    for (int i = 0; i < 3; i++) begin
      a = i[1:0];
      @(posedge clk);
      jkAsync <= a;
      storeAsync <= a;
      #1;
      chk("jkQn", {7'h00, ~a[0]}, {7'h00, jkQn});
      chk("latchRsQ", {8{a[0] & ~a[1]}}, latchRsQ);
      chk("regRsQ", {8{a[0] & ~a[1]}}, regRsQ);
      chk("latchDualQ", {8{~a[1]}}, latchDualQ);
      chk("latchDualQn", {8{~a[0]}}, latchDualQn);
    end
    @(posedge clk);
    jkAsync <= 2'h3;
    storeAsync <= 2'h3;
    #1;
    chk("regRsQ", 8'h00, regRsQ);
    chk("jkQ", 8'h00, {7'h00, jkQ});
    $display("async test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_jk();
    t_store();
    t_async();
    stop_test();
  end
endmodule
bind ssp_storage ssp_storage_props #(.WIDTH(WIDTH)) u_props (.clk, .reset,
  .jSet, .kClear, .storeEnable, .jkAsync, .storeAsync, .jkQ, .jkQn,
  .latchRsQ, .regRsQ,
  .regDualQ, .regDualQn);
